// ===== design/psr_top.sv
// Purpose: Processor status word with system byte and condition codes
// Assumes: Execution and interrupt inputs come from core-clock logic
// Notes:   Register access over APB; privilege bit gates the system byte
//
// How it works
// - Trace: 00 off, 01 flow changes, 10 all instructions, 11 reserved.
// - Privilege bit 0 means user level, 1 means supervisor level.
// - Three-bit mask 0..7 blocks interrupts not above it.
// - Condition codes sit in the low byte; system byte is upper.
// - User access reaches only low byte; supervisor reaches whole word.
// - Extend flag loads the carry value for arithmetic and shifts.
// - Negative flag copies the result's most significant bit.
// - Zero flag set exactly when the whole result is zero.
// - Overflow flag set on two's complement overflow only.
// - Carry flag marks carry or borrow; shifts load it with the bit shifted out.
//
// Added by the designer: the APB interface to the registers and the address map.

`timescale 1ns/1ps
`default_nettype none

module psr_top #(
  parameter int unsigned DATA_W = 32 // Execution operand width
) (
  input wire logic pclk, // Core clock, 125 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [psr_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic exec_valid, // Instruction executes now
  input wire psr_pkg::psr_op_e exec_op, // Flag-setting operation
  input wire logic [DATA_W-1:0] exec_a, // First operand
  input wire logic [DATA_W-1:0] exec_b, // Second operand
  input wire logic flow_change, // Instruction changed flow
  input wire logic [2:0] irq_level, // Pending interrupt level
  output logic [DATA_W-1:0] exec_result_q, // Last result
  output logic supervisor_q, // Core at supervisor level
  output logic irq_request_q, // Pending level beats mask
  output logic trace_req_q // Trace exception request
);
  import psr_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DATA_W < 2) begin : g_chk
    $error("DATA_W must be at least 2");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] psw_q;
  logic [31:0] prdata_q;
  logic addr_hit;
  logic setup_rd;
  logic wr_commit;
  logic wr_lo;
  logic wr_hi;
  logic exec_fire;
  logic priv;
  logic [2:0] mask;
  psr_trace_e trace_sel;
  logic [DATA_W-1:0] alu_result;
  logic alu_v;
  logic alu_c;
  logic alu_x_load;

  // Field views of the status word
  assign priv = psw_q[PRIV_BIT];
  assign mask = psw_q[MASK_LSB +: 3];
  assign trace_sel = psr_trace_e'(psw_q[TRACE_LSB +: 2]);
  assign exec_fire = exec_valid && (exec_op != OP_NONE);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign addr_hit = (paddr == PSW_OFFSET);

  psr_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .addr_hit(addr_hit),
    .setup_rd(setup_rd),
    .wr_commit(wr_commit),
    .pready_q(pready),
    .pslverr_q(pslverr)
  );

  // Byte lane writes; system byte only at supervisor level
  assign wr_lo = wr_commit & pstrb[0];
  assign wr_hi = wr_commit & pstrb[1] & priv;

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      if (!addr_hit) begin
        prdata_q <= 32'h0000_0000;
      end else if (priv) begin
        prdata_q <= {16'h0000, psw_q};
      end else begin
        prdata_q <= {24'h00_0000, psw_q[7:0]};
      end
    end
  end

  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // Execution flag calculation
  // ----------------------------------------------------------------
  psr_flag_calc #(
    .DATA_W(DATA_W)
  ) u_flags (
    .op(exec_op),
    .a(exec_a),
    .b(exec_b),
    .x_in(psw_q[X_BIT]),
    .result(alu_result),
    .flag_v(alu_v),
    .flag_c(alu_c),
    .x_load(alu_x_load)
  );

  // Result register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_result_q <= '0;
    end else if (exec_fire) begin
      exec_result_q <= alu_result;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Software writes first; execution updates of flags win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psw_q <= PSW_RESET;
    end else begin
      if (wr_hi) begin
        psw_q[15:8] <= pwdata[15:8] & PSW_WR_MASK[15:8];
      end
      if (wr_lo) begin
        psw_q[7:0] <= pwdata[7:0] & PSW_WR_MASK[7:0];
      end
      if (exec_fire) begin
        psw_q[N_BIT] <= alu_result[DATA_W-1];
        psw_q[Z_BIT] <= (alu_result == '0);
        psw_q[V_BIT] <= alu_v;
        psw_q[C_BIT] <= alu_c;
        if (alu_x_load) begin
          psw_q[X_BIT] <= alu_c;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Core control outputs
  // ----------------------------------------------------------------
  // Privilege level seen by the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supervisor_q <= RST_PRIV;
    end else begin
      supervisor_q <= priv;
    end
  end

  // Interrupt masking by priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request_q <= 1'b0;
    end else begin
      irq_request_q <= (irq_level > mask);
    end
  end

  // Trace requests per executed instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_req_q <= 1'b0;
    end else begin
      case (trace_sel)
        TRACE_OFF: trace_req_q <= 1'b0;
        TRACE_FLOW: trace_req_q <= exec_valid & flow_change;
        TRACE_ALL: trace_req_q <= exec_valid;
        default: trace_req_q <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  trace_flow_a: assert property (
    (trace_sel == TRACE_FLOW) && exec_valid |=>
      trace_req_q == $past(flow_change)
  ) else $error("flow trace request wrong");

  trace_all_a: assert property (
    (trace_sel == TRACE_ALL) |=> trace_req_q == $past(exec_valid)
  ) else $error("instruction trace request wrong");

  trace_off_a: assert property (
    (trace_sel == TRACE_OFF) || (trace_sel == TRACE_RSVD) |=> !trace_req_q
  ) else $error("trace request while tracing off");

  irq_mask_a: assert property (
    (irq_level <= mask) |=> !irq_request_q
  ) else $error("masked interrupt requested");

  irq_pass_a: assert property (
    (irq_level > mask) ##1 (irq_level > mask) |-> irq_request_q
  ) else $error("unmasked interrupt not requested");

  user_sysbyte_a: assert property (
    wr_commit && !priv |=> $stable(psw_q[15:8])
  ) else $error("user write changed system byte");

  user_read_a: assert property (
    setup_rd && !priv ##1 pready |-> prdata[31:8] == 24'h00_0000
  ) else $error("user read exposed system byte");

  sup_read_a: assert property (
    setup_rd && priv && addr_hit ##1 pready |->
      prdata == {16'h0000, $past(psw_q)}
  ) else $error("supervisor read wrong");

  sup_write_a: assert property (
    wr_commit && priv && pstrb[1] |=>
      psw_q[15:8] == ($past(pwdata[15:8]) & PSW_WR_MASK[15:8])
  ) else $error("supervisor write to system byte lost");

  low_write_a: assert property (
    wr_lo && !exec_fire |=>
      psw_q[7:0] == ($past(pwdata[7:0]) & PSW_WR_MASK[7:0])
  ) else $error("condition byte write lost");

  neg_flag_a: assert property (
    exec_fire |=> psw_q[N_BIT] == exec_result_q[DATA_W-1]
  ) else $error("negative flag mismatch");

  zero_flag_a: assert property (
    exec_fire |=> psw_q[Z_BIT] == (exec_result_q == '0)
  ) else $error("zero flag mismatch");

  ext_carry_a: assert property (
    exec_fire && alu_x_load |=> psw_q[X_BIT] == psw_q[C_BIT]
  ) else $error("extend flag differs from carry");

  ext_hold_a: assert property (
    exec_fire && !alu_x_load && !wr_lo |=> $stable(psw_q[X_BIT])
  ) else $error("extend flag changed by logic op");

  // Flag checks against plain operand arithmetic
  add_carry_a: assert property (
    exec_fire && (exec_op == OP_ADD) |=>
      {psw_q[C_BIT], exec_result_q} ==
        ({1'b0, $past(exec_a)} + {1'b0, $past(exec_b)})
  ) else $error("add carry or sum wrong");

  sub_borrow_a: assert property (
    exec_fire && (exec_op == OP_SUB) |=>
      psw_q[C_BIT] == ($past(exec_a) < $past(exec_b))
  ) else $error("subtract borrow wrong");

  lsl_carry_a: assert property (
    exec_fire && (exec_op == OP_LSL) |=>
      psw_q[C_BIT] == $past(exec_a[DATA_W-1]) && !psw_q[V_BIT]
  ) else $error("shift carry wrong");

  logic_clear_a: assert property (
    exec_fire && (exec_op == OP_LOGIC) |=> !psw_q[V_BIT] && !psw_q[C_BIT]
  ) else $error("logic op left overflow or carry");

  zero_bits_a: assert property (
    (psw_q & ~PSW_WR_MASK) == 16'h0000
  ) else $error("unused status bit set");

  priv_out_a: assert property (
    wr_hi && !pwdata[PRIV_BIT] |=> ##1 !supervisor_q
  ) else $error("privilege drop not seen by core");

endmodule

`default_nettype wire

// ===== design/psr_pkg.sv
// Purpose: Shared constants and types of the processor status word block
// Assumes: One core clock; APB register access with 8-bit byte address
// Notes:   Field positions, reset values and opcodes live here only

`default_nettype none

package psr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] PSW_OFFSET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions within the status word
  // ----------------------------------------------------------------
  localparam int unsigned TRACE_LSB = 14;
  localparam int unsigned PRIV_BIT = 13;
  localparam int unsigned MASK_LSB = 8;
  localparam int unsigned X_BIT = 4;
  localparam int unsigned N_BIT = 3;
  localparam int unsigned Z_BIT = 2;
  localparam int unsigned V_BIT = 1;
  localparam int unsigned C_BIT = 0;

  // Implemented bits; the rest read zero and ignore writes
  localparam logic [15:0] PSW_WR_MASK = 16'he71f;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_TRACE = 2'h0;
  localparam logic RST_PRIV = 1'b1;
  localparam logic [2:0] RST_MASK = 3'h7;
  localparam logic [4:0] RST_CCR = 5'h00;
  localparam logic [15:0] PSW_RESET = {RST_TRACE, RST_PRIV, 2'h0,
                                       RST_MASK, 3'h0, RST_CCR};

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRACE_OFF = 2'b00,
    TRACE_FLOW = 2'b01,
    TRACE_ALL = 2'b10,
    TRACE_RSVD = 2'b11
  } psr_trace_e;

  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_SUB = 3'b001,
    OP_ADDX = 3'b010,
    OP_SUBX = 3'b011,
    OP_LSL = 3'b100,
    OP_ROXL = 3'b101,
    OP_LOGIC = 3'b110,
    OP_NONE = 3'b111
  } psr_op_e;

  typedef enum logic {
    APB_IDLE = 1'b0,
    APB_ACK = 1'b1
  } psr_apb_e;

endpackage

`default_nettype wire

// ===== design/psr_flag_calc.sv
// Purpose: Result and condition flags of one execution operation
// Assumes: Purely combinational; the caller registers the outputs
// Notes:   Extend flag is loaded only by arithmetic and shift operations

`timescale 1ns/1ps
`default_nettype none

module psr_flag_calc #(
  parameter int unsigned DATA_W = 32 // Operand width
) (
  input wire psr_pkg::psr_op_e op, // Operation
  input wire logic [DATA_W-1:0] a, // First operand
  input wire logic [DATA_W-1:0] b, // Second operand
  input wire logic x_in, // Current extend flag
  output logic [DATA_W-1:0] result, // Operation result
  output logic flag_v, // Two's complement overflow
  output logic flag_c, // Carry or borrow out
  output logic x_load // Extend flag takes carry
);
  import psr_pkg::*;

  logic [DATA_W:0] sum;
  logic [DATA_W:0] diff;
  logic cin;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DATA_W < 2) begin : g_chk
    $error("DATA_W must be at least 2");
  end

  // Extended operations chain through the extend flag
  assign cin = (op == OP_ADDX || op == OP_SUBX) ? x_in : 1'b0;
  assign sum = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
  assign diff = {1'b0, a} - {1'b0, b} - {{DATA_W{1'b0}}, cin};

  // ----------------------------------------------------------------
  // Per-operation result and flags
  // ----------------------------------------------------------------
  always_comb begin
    result = a;
    flag_v = 1'b0;
    flag_c = 1'b0;
    x_load = 1'b0;
    case (op)
      OP_ADD, OP_ADDX: begin
        result = sum[DATA_W-1:0];
        flag_c = sum[DATA_W];
        flag_v = (a[DATA_W-1] == b[DATA_W-1]) &&
                 (sum[DATA_W-1] != a[DATA_W-1]);
        x_load = 1'b1;
      end
      OP_SUB, OP_SUBX: begin
        result = diff[DATA_W-1:0];
        flag_c = diff[DATA_W];
        flag_v = (a[DATA_W-1] != b[DATA_W-1]) &&
                 (diff[DATA_W-1] != a[DATA_W-1]);
        x_load = 1'b1;
      end
      OP_LSL: begin
        result = {a[DATA_W-2:0], 1'b0};
        flag_c = a[DATA_W-1];
        x_load = 1'b1;
      end
      OP_ROXL: begin
        result = {a[DATA_W-2:0], x_in};
        flag_c = a[DATA_W-1];
        x_load = 1'b1;
      end
      OP_LOGIC: begin
        result = a & b;
      end
      default: begin
        result = a;
      end
    endcase
  end

endmodule

`default_nettype wire

// ===== design/psr_apb_slave.sv
// Purpose: APB handshake for the status word registers
// Assumes: Zero wait states; answer one cycle after setup
// Notes:   Unmapped addresses answer with pslverr

`timescale 1ns/1ps
`default_nettype none

module psr_apb_slave (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // Slave select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Write direction
  input wire logic addr_hit, // Address is mapped
  output logic setup_rd, // Read setup cycle pulse
  output logic wr_commit, // Mapped write takes effect
  output logic pready_q, // Transfer answer
  output logic pslverr_q // Unmapped address error
);
  import psr_pkg::*;

  psr_apb_e state_q;
  logic setup;

  assign setup = psel & ~penable;
  assign setup_rd = setup & ~pwrite;
  assign wr_commit = psel & penable & pwrite & pready_q & addr_hit;

  // ----------------------------------------------------------------
  // Answer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= APB_IDLE;
    end else begin
      case (state_q)
        APB_IDLE: begin
          if (setup) begin
            state_q <= APB_ACK;
          end
        end
        APB_ACK: begin
          state_q <= APB_IDLE;
        end
        default: begin
          state_q <= APB_IDLE;
        end
      endcase
    end
  end

  // Ready and error flops follow the answer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= (state_q == APB_IDLE) && setup;
      pslverr_q <= (state_q == APB_IDLE) && setup && !addr_hit;
    end
  end

endmodule

`default_nettype wire

// ===== tb/psr_top_bench.sv
// Purpose: Self-checking bench for the processor status word block
// Assumes: APB answers in one access cycle; core clock of 125 MHz
// Notes:   Design-side assertions live beside the logic in the design

`timescale 1ns/1ps
`default_nettype none

module psr_top_bench;
  import psr_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, exec_a, exec_b, exec_result_q, rd;
  logic [3:0] pstrb;
  logic exec_valid, flow_change, supervisor_q, irq_request_q;
  logic trace_req_q, err;
  psr_op_e exec_op;
  logic [2:0] irq_level;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  psr_top #(.DATA_W(32)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exec_valid(exec_valid), .exec_op(exec_op), .exec_a(exec_a),
    .exec_b(exec_b), .flow_change(flow_change), .irq_level(irq_level),
    .exec_result_q(exec_result_q), .supervisor_q(supervisor_q),
    .irq_request_q(irq_request_q), .trace_req_q(trace_req_q)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and closing report
  // ----------------------------------------------------------------
  // Free-running 8 ns core clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Bus, execution and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Setup then access; waits for pready, holding the request
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [15:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr16(input logic [15:0] d);
    apb(1'b1, PSW_OFFSET, d, 4'h3);
  endtask

  task automatic rd16();
    apb(1'b0, PSW_OFFSET, 16'h0000, 4'h0);
  endtask

  // One executed instruction; outputs checked after the update edge
  task automatic exec(input psr_op_e op, input logic [31:0] a, b,
                      input logic fc);
    @(posedge pclk);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_a <= a;
    exec_b <= b;
    flow_change <= fc;
    @(posedge pclk);
    exec_valid <= 1'b0;
    exec_op <= OP_NONE;
    flow_change <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic flag(input psr_op_e op, input logic [31:0] a, b, res,
                      input logic [4:0] condition_code_byte);
    exec(op, a, b, 1'b0);
    chk(exec_result_q, res);
    rd16();
    chk(rd, {16'h0000, 8'h27, 3'h0, condition_code_byte});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset value and full-word supervisor access with fixed-zero bits
  task automatic t_supv_word();
    rd16();
    chk(rd, 32'h00002700);
    chk({31'h0, supervisor_q}, 32'h1);
    wr16(16'hffff);
    rd16();
    chk(rd, 32'h0000e71f);
    apb(1'b1, PSW_OFFSET, 16'h0000, 4'h1);
    rd16();
    chk(rd, 32'h0000e700);
    apb(1'b1, PSW_OFFSET, 16'h2700, 4'h2);
    apb(1'b0, 8'h04, 16'h0000, 4'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 8'h04, 16'h0000, 4'h3);
    chk({31'h0, err}, 32'h1);
    rd16();
    chk(rd, 32'h00002700);
  endtask

  // Every trace mode with and without a flow change
  task automatic t_trace();
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      for (int f = 0; f < 2; f++) begin
        m = i[1:0];
        wr16({m, 6'h27, 8'h00});
        exec(OP_NONE, 32'h0, 32'h0, f[0]);
        chk({31'h0, trace_req_q}, (m == 2'h1) ? f : (m == 2'h2));
      end
    end
    wr16(16'h2700);
  endtask

  // Each mask value, level at and just above it
  task automatic t_irq();
    for (int m = 0; m < 8; m++) begin
      wr16({5'h04, m[2:0], 8'h00});
      irq_level <= m[2:0];
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, irq_request_q}, 32'h0);
      if (m < 7) begin
        @(posedge pclk);
        irq_level <= m[2:0] + 3'h1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, irq_request_q}, 32'h1);
      end
    end
    irq_level <= 3'h0;
    wr16(16'h2700);
  endtask

  // Flag updates for every operation kind, chained through extend
  task automatic t_flags();
    flag(OP_ADD, 32'h7fffffff, 32'h1, 32'h80000000, 5'h0a);
    flag(OP_ADD, 32'hffffffff, 32'h1, 32'h0, 5'h15);
    flag(OP_LOGIC, 32'hf0, 32'h0f, 32'h0, 5'h14);
    flag(OP_SUB, 32'h0, 32'h1, 32'hffffffff, 5'h19);
    flag(OP_ADDX, 32'h1, 32'h1, 32'h3, 5'h00);
    flag(OP_ROXL, 32'h80000000, 32'h1, 32'h0, 5'h15);
    flag(OP_LSL, 32'hc0000000, 32'h1, 32'h80000000, 5'h19);
    flag(OP_SUBX, 32'h5, 32'h2, 32'h2, 5'h00);
    flag(OP_NONE, 32'hffffffff, 32'h1, 32'h2, 5'h00);
  endtask

  // Drop to user level, then only the condition byte is reachable
  task automatic t_user();
    wr16(16'h0000);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, supervisor_q}, 32'h0);
    wr16(16'hffff);
    rd16();
    chk(rd, 32'h0000001f);
  endtask

  // Mid-run reset brings the word back to its reset value
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd16();
    chk(rd, 32'h00002700);
    chk({31'h0, supervisor_q}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    exec_valid = 1'b0;
    exec_op = OP_NONE;
    exec_a = '0;
    exec_b = '0;
    flow_change = 1'b0;
    irq_level = 3'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_supv_word();
    t_trace();
    t_irq();
    t_flags();
    t_user();
    t_reset();
    test_done();
  end

endmodule

`default_nettype wire
